// ==== rtl/dbg_mode_defs.svh ====
/*
 * constants for the debug mode control block: register offsets, field positions, resets.
 * assumes inclusion by bare name from the package and the design module.
 */
`ifndef DBG_MODE_DEFS_SVH
`define DBG_MODE_DEFS_SVH
`define OFS_CTRL0 4'h0
`define OFS_STATUS 4'h1
`define OFS_MSTATE 4'h2
`define OFS_IRQ_STAT 4'h3
`define OFS_IRQ_MASK 4'h4
`define OFS_RUNSTATE 4'h5
`define NUM_EVT 9
`define EVT_UNCOND 8
`define CTRL_IDM_BIT 9
`define CTRL_EDM_BIT 10
`define MS_DE_BIT 0
`define MS_DWE_BIT 1
`define CTRL0_RST 11'h000
`define MSTATE_RST 2'h0
`define IRQ_STOP_BIT 0
`define IRQ_DBGINT_BIT 1
`define IRQ_RESUME_BIT 2
`endif

// ==== rtl/dbg_mode_pkg.sv ====
/*
 * types for the debug mode control block.
 * assumes dbg_mode_defs.svh is on the include path.
 */
package dbg_mode_pkg;
  `include "dbg_mode_defs.svh"
  typedef enum logic [1:0] {RUN, STOPPED, INT_TAKE} run_state_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic resume;
    logic step;
    logic dwe_ext;
    logic uncond;
  } jtag_ctl_t;
  typedef struct packed {
    logic int_req;
    logic int_return;
    logic saved_dwe;
  } core_evt_t;
endpackage : dbg_mode_pkg

// ==== rtl/debug_mode_control.sv ====
/*
 * debug mode selection and disposition of debug events: record, stop, interrupt, trace.
 * assumes event pulses from the comparators, core interrupt and return pulses, and
 * jtag controller levels and pulses all synchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "dbg_mode_defs.svh"
module debug_mode_control
  import dbg_mode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  input wire logic [`NUM_EVT-1:0] evt_raw,
  input wire jtag_ctl_t jtag_ctl,
  input wire core_evt_t core_evt,
  input wire logic pending_int,
  output logic core_halt,
  output logic jtag_access,
  output logic mmu_check_on,
  output logic debug_int_req,
  output logic int_hold_off,
  output logic trace_valid,
  output logic [`NUM_EVT-1:0] trace_evt,
  output logic irq
);
  logic [10:0] ctrl_r, ctrl_nxt;
  logic [`NUM_EVT-1:0] status_r, status_nxt;
  logic [1:0] mstate_r, mstate_nxt;
  logic [2:0] irq_stat_r, irq_stat_nxt;
  logic [2:0] irq_mask_r, irq_mask_nxt;
  run_state_t state_r, state_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic halt_r, jacc_r, dint_r, hold_r, tval_r, irq_r;
  logic [`NUM_EVT-1:0] tevt_r;
  logic halt_nxt, jacc_nxt, dint_nxt, hold_nxt, tval_nxt, irq_nxt;
  logic [`NUM_EVT-1:0] tevt_nxt, evt_en, evt_hit;
  logic internal_mode_enable, external_mode_enable, dwm, de, any_evt, go_stop, go_int;
  logic ev_stop, ev_dint, ev_resume;
  logic mmu_r;

  function automatic logic hit(input reg_req_t r, input logic [3:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  always_comb begin
    evt_en = {1'b1, ctrl_r[`NUM_EVT-2:0]};
    evt_hit = evt_raw & evt_en;
    any_evt = |evt_hit;
    internal_mode_enable = ctrl_r[`CTRL_IDM_BIT];
    external_mode_enable = ctrl_r[`CTRL_EDM_BIT];
    de = mstate_r[`MS_DE_BIT];
    dwm = mstate_r[`MS_DWE_BIT] && jtag_ctl.dwe_ext;
    // external first, then internal with interrupts on, then wait mode
    go_stop = 1'b0;
    go_int = 1'b0;
    if (any_evt && state_r == RUN) begin
      if (external_mode_enable) begin
        go_stop = 1'b1;
      end else if (internal_mode_enable && de) begin
        go_int = 1'b1;
      end else if (dwm) begin
        go_stop = 1'b1;
      end
      // neither: trace only
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    status_nxt = status_r;
    mstate_nxt = mstate_r;
    irq_mask_nxt = irq_mask_r;
    state_nxt = state_r;
    dint_nxt = dint_r;
    ev_stop = go_stop;
    ev_dint = 1'b0;
    ev_resume = 1'b0;
    if (hit(reg_req, `OFS_CTRL0)) ctrl_nxt = reg_req.wdata[10:0];
    if (hit(reg_req, `OFS_MSTATE)) mstate_nxt = reg_req.wdata[1:0];
    if (hit(reg_req, `OFS_IRQ_MASK)) irq_mask_nxt = reg_req.wdata[2:0];
    // status clears by write one; new events win over the clear
    if (hit(reg_req, `OFS_STATUS)) status_nxt = status_r & ~reg_req.wdata[`NUM_EVT-1:0];
    status_nxt = status_nxt | evt_hit;
    // core takes interrupt: wait enable drops, return restores saved copy
    if (core_evt.int_req) begin
      mstate_nxt[`MS_DWE_BIT] = 1'b0;
    end else if (core_evt.int_return) begin
      mstate_nxt[`MS_DWE_BIT] = core_evt.saved_dwe;
    end
    // core took the pending debug interrupt; a new one set below still wins
    if (core_evt.int_req) begin
      dint_nxt = 1'b0;
    end
    case (state_r)
      RUN: begin
        if (go_stop) begin
          state_nxt = STOPPED;
          // internal also on with interrupts: leave it pending
          if (internal_mode_enable && de) dint_nxt = 1'b1;
        end else if (go_int) begin
          state_nxt = INT_TAKE;
          dint_nxt = 1'b1;
          ev_dint = 1'b1;
        end else if (dint_r && !core_evt.int_req && internal_mode_enable && de) begin
          ev_dint = 1'b0;
        end
      end
      STOPPED: begin
        if (jtag_ctl.resume || jtag_ctl.step) begin
          state_nxt = RUN;
          ev_resume = 1'b1;
        end else if (!external_mode_enable && dwm && pending_int) begin
          state_nxt = RUN;
          ev_resume = 1'b1;
        end
      end
      INT_TAKE: begin
        if (core_evt.int_req) begin
          state_nxt = RUN;
          dint_nxt = 1'b0;
        end
      end
      default: state_nxt = RUN;
    endcase
  end

  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (hit(reg_req, `OFS_IRQ_STAT)) irq_stat_nxt = irq_stat_r & ~reg_req.wdata[2:0];
    irq_stat_nxt[`IRQ_STOP_BIT] = irq_stat_nxt[`IRQ_STOP_BIT] | ev_stop;
    irq_stat_nxt[`IRQ_DBGINT_BIT] = irq_stat_nxt[`IRQ_DBGINT_BIT] | ev_dint;
    irq_stat_nxt[`IRQ_RESUME_BIT] = irq_stat_nxt[`IRQ_RESUME_BIT] | ev_resume;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    halt_nxt = (state_nxt == STOPPED);
    jacc_nxt = (state_nxt == STOPPED);
    // interrupts held off only when stopped without wait mode taking over
    hold_nxt = (state_nxt == STOPPED) && (external_mode_enable || !dwm);
    tval_nxt = any_evt;
    tevt_nxt = evt_hit;
    rdata_nxt = 32'h0000_0000;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `OFS_CTRL0: rdata_nxt = {21'h0, ctrl_r};
        `OFS_STATUS: rdata_nxt = {23'h0, status_r};
        `OFS_MSTATE: rdata_nxt = {30'h0, mstate_r};
        `OFS_IRQ_STAT: rdata_nxt = {29'h0, irq_stat_r};
        `OFS_IRQ_MASK: rdata_nxt = {29'h0, irq_mask_r};
        `OFS_RUNSTATE: rdata_nxt = {29'h0, dint_r, state_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= `CTRL0_RST;
      status_r <= '0;
      mstate_r <= `MSTATE_RST;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      state_r <= RUN;
      dint_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      halt_r <= 1'b0;
      jacc_r <= 1'b0;
      hold_r <= 1'b0;
      tval_r <= 1'b0;
      tevt_r <= '0;
      irq_r <= 1'b0;
      mmu_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      status_r <= status_nxt;
      mstate_r <= mstate_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      state_r <= state_nxt;
      dint_r <= dint_nxt;
      rdata_r <= rdata_nxt;
      halt_r <= halt_nxt;
      jacc_r <= jacc_nxt;
      hold_r <= hold_nxt;
      tval_r <= tval_nxt;
      tevt_r <= tevt_nxt;
      irq_r <= irq_nxt;
      mmu_r <= 1'b1;
    end
  end

  assign reg_rdata = rdata_r;
  assign core_halt = halt_r;
  assign jtag_access = jacc_r;
  assign debug_int_req = dint_r;
  assign int_hold_off = hold_r;
  assign trace_valid = tval_r;
  assign trace_evt = tevt_r;
  assign irq = irq_r;
  // protection never bypassed for debugger traffic
  assign mmu_check_on = mmu_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  status_records_a: assert property (evt_hit[0] |=> status_r[0])
    else $error("enabled event not recorded");

  uncond_gate_a: assert property (evt_raw[`EVT_UNCOND] |=> status_r[`EVT_UNCOND])
    else $error("unconditional event not recorded");

  gated_event_a: assert property (
    evt_raw[0] && !ctrl_r[0] && !status_r[0] && !hit(reg_req, `OFS_STATUS) |=> !status_r[0])
    else $error("disabled event recorded");

  int_mode_a: assert property (state_r == RUN && any_evt && !external_mode_enable && internal_mode_enable && de
    |=> debug_int_req && !core_halt)
    else $error("internal mode event did not interrupt");

  ext_stop_a: assert property (
    state_r == RUN && any_evt && external_mode_enable |=> core_halt && int_hold_off)
    else $error("external mode event did not stop");

  no_int_dbg_a: assert property (state_r == RUN && any_evt && !external_mode_enable && !(internal_mode_enable && de) && !dwm
    |=> !core_halt && $stable(debug_int_req))
    else $error("trace mode stopped or interrupted");

  wait_stop_a: assert property (state_r == RUN && any_evt && !external_mode_enable && !(internal_mode_enable && de) && dwm
    |=> core_halt && !int_hold_off)
    else $error("wait mode event did not stop");

  stop_holds_a: assert property (state_r == STOPPED && !jtag_ctl.resume && !jtag_ctl.step
    && !(dwm && pending_int) |=> core_halt)
    else $error("left stop state without cause");

  dwe_clear_a: assert property (core_evt.int_req |=> !mstate_r[`MS_DWE_BIT])
    else $error("interrupt did not clear wait enable");

  trace_out_a: assert property (
    any_evt |=> trace_valid && trace_evt == $past(evt_hit))
    else $error("trace not signalled");

  jtag_same_a: assert property (jtag_access == core_halt)
    else $error("jtag access differs from stop state");

  mmu_on_a: assert property (mmu_check_on)
    else $error("protection checks dropped");

  hold_in_stop_a: assert property (int_hold_off |-> core_halt)
    else $error("interrupts held off while running");

  hold_ext_a: assert property (state_r == STOPPED && external_mode_enable
    && !jtag_ctl.resume && !jtag_ctl.step |=> int_hold_off)
    else $error("external stop let interrupts through");

  idm_off_a: assert property (state_r == RUN && any_evt && !internal_mode_enable
    |=> !$rose(debug_int_req))
    else $error("debug interrupt without internal mode");

  de_off_a: assert property (state_r == RUN && any_evt && !de
    |=> !$rose(debug_int_req))
    else $error("debug interrupt while interrupts disabled");

  both_pend_a: assert property (state_r == RUN && any_evt && external_mode_enable && internal_mode_enable && de
    |=> core_halt && debug_int_req)
    else $error("combined mode did not stop with interrupt pending");

  wait_int_a: assert property (state_r == RUN && any_evt && !external_mode_enable && internal_mode_enable && de && dwm
    |=> debug_int_req && !core_halt)
    else $error("internal plus wait did not interrupt");

  wait_de0_a: assert property (state_r == RUN && any_evt && !external_mode_enable && internal_mode_enable && !de && dwm
    |=> core_halt && !int_hold_off)
    else $error("internal plus wait with interrupts off did not stop");

  wake_wait_a: assert property (state_r == STOPPED && !external_mode_enable && dwm && pending_int
    |=> !core_halt)
    else $error("wait mode stop not left on interrupt");

  resume_a: assert property (
    state_r == STOPPED && (jtag_ctl.resume || jtag_ctl.step) |=> !core_halt)
    else $error("resume or step ignored");

  ext_no_wake_a: assert property (state_r == STOPPED && external_mode_enable && pending_int
    && !jtag_ctl.resume && !jtag_ctl.step |=> core_halt)
    else $error("external stop woken by interrupt");

  dwe_restore_a: assert property (!core_evt.int_req && core_evt.int_return
    |=> mstate_r[`MS_DWE_BIT] == $past(core_evt.saved_dwe))
    else $error("return did not restore wait enable");

  dint_drop_a: assert property (
    core_evt.int_req && !(any_evt && state_r == RUN && internal_mode_enable && de) |=> !debug_int_req)
    else $error("debug interrupt not dropped when taken");

  status_sticky_a: assert property (
    status_r[0] && !hit(reg_req, `OFS_STATUS) |=> status_r[0])
    else $error("status bit lost without clear");

  status_clear_a: assert property (
    hit(reg_req, `OFS_STATUS) && reg_req.wdata[0] && !evt_hit[0] |=> !status_r[0])
    else $error("write one did not clear status");

  trace_idle_a: assert property (!any_evt |=> !trace_valid)
    else $error("trace without event");

  gate_en_a: assert property (evt_raw[1] && ctrl_r[1] |=> status_r[1])
    else $error("enabled event one not recorded");

  irq_level_a: assert property (irq == |(irq_stat_r & irq_mask_r))
    else $error("interrupt output does not follow status and mask");

  stop_irq_a: assert property (ev_stop |=> irq_stat_r[`IRQ_STOP_BIT])
    else $error("stop event not flagged");

  halt_state_a: assert property (core_halt == (state_r == STOPPED))
    else $error("halt output differs from state");

  dwe_need_a: assert property (state_r == RUN && any_evt && !external_mode_enable && !(internal_mode_enable && de)
    && !jtag_ctl.dwe_ext |=> !core_halt)
    else $error("wait mode without jtag enable");

  msr_need_a: assert property (state_r == RUN && any_evt && !external_mode_enable && !(internal_mode_enable && de)
    && !mstate_r[`MS_DWE_BIT] |=> !core_halt)
    else $error("wait mode without state enable");

  // scenarios worth seeing at least once
  cov_ext_stop: cover property (state_r == RUN && any_evt && external_mode_enable ##1 core_halt);
  cov_int_take: cover property (go_int ##[1:20] core_evt.int_req);
  cov_wait_wake: cover property (core_halt && !int_hold_off ##[1:20] !core_halt);
  cov_trace_only: cover property (any_evt && !go_stop && !go_int ##1 trace_valid);
  cov_both_pend: cover property (go_stop && internal_mode_enable && de ##1 core_halt && debug_int_req);
endmodule : debug_mode_control

// ==== testbench/jtag_model.sv ====
/* jtag controller model: wait-enable level, resume or step some cycles after a stop.
   assumes core_halt from the block, everything on sys_clk. */
`timescale 1ns/1ps
module jtag_model
  import dbg_mode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic core_halt,
  input wire logic wait_on,
  input wire logic use_step,
  output jtag_ctl_t jtag_ctl
);
  logic [3:0] cnt_r = 4'h0;
  initial jtag_ctl = '0;
  // slow on purpose: a wake-up in wait mode must beat the resume
  always @(posedge sys_clk) begin
    jtag_ctl.resume <= 1'b0;
    jtag_ctl.step <= 1'b0;
    jtag_ctl.dwe_ext <= wait_on;
    cnt_r <= (core_halt && !rst) ? cnt_r + 4'h1 : 4'h0;
    if (cnt_r == 4'h6) begin
      jtag_ctl.resume <= ~use_step;
      jtag_ctl.step <= use_step;
    end
  end
endmodule : jtag_model

// ==== testbench/debug_mode_control_tb_top.sv ====
/* self-checking bench for the debug mode control block.
   assumes the jtag model on the far side and a 200 MHz sys_clk. */
`timescale 1ns/1ps
module debug_mode_control_tb_top
  import dbg_mode_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t reg_req = '0;
  logic [8:0] evt_raw = '0;
  core_evt_t core_evt = '0;
  logic pending_int = 1'b0, wait_on = 1'b0, use_step = 1'b0;
  jtag_ctl_t jtag_ctl;
  logic [31:0] reg_rdata, d;
  logic core_halt, jtag_access, mmu_check_on, debug_int_req, int_hold_off, trace_valid, irq;
  logic [8:0] trace_evt;
  int fail_count = 0, tests_run = 0;
  always #2.5 sys_clk = ~sys_clk;
  debug_mode_control u_debug_mode_control (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .evt_raw(evt_raw), .jtag_ctl(jtag_ctl), .core_evt(core_evt),
    .pending_int(pending_int), .core_halt(core_halt), .jtag_access(jtag_access),
    .mmu_check_on(mmu_check_on), .debug_int_req(debug_int_req),
    .int_hold_off(int_hold_off), .trace_valid(trace_valid), .trace_evt(trace_evt), .irq(irq));
  jtag_model u_jtag_model (.sys_clk(sys_clk), .rst(rst), .core_halt(core_halt),
    .wait_on(wait_on), .use_step(use_step), .jtag_ctl(jtag_ctl));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge sys_clk) reg_req <= '{a, v, 1'b1, 1'b0};
    @(posedge sys_clk) reg_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a);
    @(posedge sys_clk) reg_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk) reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic fire(logic [8:0] e);
    @(posedge sys_clk) evt_raw <= e;
    @(posedge sys_clk) evt_raw <= '0;
    #1;
  endtask : fire
  task automatic core_pulse(core_evt_t c);
    @(posedge sys_clk) core_evt <= c;
    @(posedge sys_clk) core_evt <= '0;
    #1;
  endtask : core_pulse
  task automatic wait_run();
    for (int i = 0; i < 20 && core_halt !== 1'b0; i++) @(posedge sys_clk);
    #1 chk("halt released", 1'b0, core_halt);
  endtask : wait_run
  // e = {halt, debug int, hold off}
  task automatic mode(logic [10:0] c, logic [1:0] ms, logic w, logic [2:0] e);
    wait_on <= w;
    wr(4'h2, ms);
    wr(4'h0, c);
    fire(9'h001);
    chk("halt", e[2], core_halt);
    chk("jtag", e[2], jtag_access);
    chk("dbg int", e[1], debug_int_req);
    chk("hold off", e[0], int_hold_off);
    chk("trace", 9'h001, trace_valid ? trace_evt : 9'h0);
    rd(4'h1);
    chk("status", 32'h1, d);
    wr(4'h1, 32'h1ff);
    if (e[1]) begin
      core_pulse('{1'b1, 1'b0, 1'b0});
      chk("dbg int drop", 1'b0, debug_int_req);
    end
    wait_run();
    $display("test mode %h %h %b done", c, ms, w);
  endtask : mode
  task automatic misc();
    fire(9'h103);
    chk("gated", 9'h100, trace_valid ? trace_evt : 9'h0);
    rd(4'h1);
    chk("gated status", 32'h100, d);
    wr(4'h1, 32'h1ff);
    wr(4'h2, 32'h3);
    core_pulse('{1'b1, 1'b0, 1'b0});
    rd(4'h2);
    chk("wait bit cleared", 32'h1, d);
    core_pulse('{1'b0, 1'b1, 1'b1});
    rd(4'h2);
    chk("wait bit back", 32'h3, d);
    wait_on <= 1'b1;
    wr(4'h2, 32'h2);
    wr(4'h0, 32'h1);
    fire(9'h001);
    chk("wait stop", 1'b1, core_halt);
    chk("wait no hold", 1'b0, int_hold_off);
    @(posedge sys_clk) pending_int <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pending_int <= 1'b0;
    @(posedge sys_clk) #1 chk("woken", 1'b0, core_halt);
    $display("test misc done");
  endtask : misc
  task automatic irq_test();
    wait_on <= 1'b0;
    wr(4'h3, 32'h7);
    wr(4'h0, 32'h401);
    fire(9'h001);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq masked", 1'b0, irq);
    wr(4'h4, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq set", 1'b1, irq);
    wr(4'h3, 32'h1);
    @(posedge sys_clk) #1 chk("irq clear", 1'b0, irq);
    rd(4'h7);
    chk("unmapped", 32'h0, d);
    wr(4'h4, 32'h0);
    wait_run();
    $display("test irq done");
  endtask : irq_test
  task automatic end_sim();
    $display("counts: %0d run, %0d mismatched", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk("mmu check", 1'b1, mmu_check_on);
    rd(4'h0);
    chk("ctrl reset", 32'h0, d);
    misc();
    mode(11'h001, 2'h0, 1'b0, 3'b000);
    mode(11'h201, 2'h1, 1'b0, 3'b010);
    mode(11'h401, 2'h0, 1'b0, 3'b101);
    mode(11'h601, 2'h1, 1'b0, 3'b111);
    mode(11'h001, 2'h2, 1'b0, 3'b000);
    mode(11'h001, 2'h0, 1'b1, 3'b000);
    use_step <= 1'b1;
    mode(11'h401, 2'h2, 1'b1, 3'b101);
    use_step <= 1'b0;
    mode(11'h201, 2'h3, 1'b1, 3'b010);
    mode(11'h201, 2'h2, 1'b1, 3'b100);
    irq_test();
    end_sim();
  end
endmodule : debug_mode_control_tb_top
